// ==== common/fds_pkg.sv ====
// Constants and register map for the fan drive ramp smoothing block
// What this block does
// - Local ramp code sets step 1,2,3,4,8,12,24,48 per time slot.
// - Fast slot: full ramp takes 37.5 s at code 0, 0.8 s at code 7.
// - Slow-ramp select set: full ramp takes 52.2 s to 1.1 s.
// - Remote one smoothing enable bit; clear means duty jumps to target.
// - Grouping bit set: sense inputs two, three, four follow drive three.
// - Grouping bit clear: only sense inputs three and four follow drive three.
// - Automatic mode: drive one below floor gives 0% or its minimum duty.
// - Automatic mode: drive two below floor gives zero or its minimum duty.
// - Automatic mode: drive three below floor gives 0% or its minimum duty.
// - Lock bit set: acoustics register writes are silently ignored.
// - Per-channel slowdown bits divide the selected ramp rate by four.
// - Remote one ramp code uses the same step encoding.
// - Automatic mode: above start threshold fan runs at least minimum duty, rising with temperature.
package fds_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CFG6     = 10'h010;
    localparam logic [9:0]  IDX_ACOU1    = 10'h062;
    localparam logic [9:0]  IDX_ACOU2    = 10'h063;
    localparam logic [9:0]  IDX_CTRL     = 10'h070;
    localparam logic [9:0]  IDX_STATUS   = 10'h071;

    // Reset values
    localparam logic [7:0]  REMOTE_ONE_RAMP_CODE_RST     = 8'h00;
    localparam logic [7:0]  CFG6_RST     = 8'h00;
    localparam logic [7:0]  DUTY_RST     = 8'h00;

    // Field positions
    localparam int          F_CODE_LO    = 0;
    localparam int          F_EN_LO      = 3;
    localparam int          F_SYNC       = 4;
    localparam int          F_OUT_ONE_FLOOR_SELECT       = 5;
    localparam int          F_CODE_HI    = 4;
    localparam int          F_EN_HI      = 7;
    localparam int          F_SLOW_SEL   = 7;
    localparam int          F_LOCK       = 0;
    localparam int          F_AUTO       = 1;

    // Step per time slot, indexed by the 3-bit rate code
    localparam logic [7:0][7:0] RAMP_STEP = {8'h30, 8'h18, 8'h0C, 8'h08,
                                             8'h04, 8'h03, 8'h02, 8'h01};

    // Full-scale ramp times at code 000 and the clock rate
    localparam real         RAMP_FULL_FAST_S = 37.5;
    localparam real         RAMP_FULL_SLOW_S = 52.2;
    localparam real         CLOCK_HZ         = 250.0e6;
    localparam real         FULL_SCALE       = 255.0;

    // Cycles per time slot, rounded down
    localparam int unsigned SLOT_FAST_CYC =
        int'($floor(RAMP_FULL_FAST_S * CLOCK_HZ / FULL_SCALE));
    localparam int unsigned SLOT_SLOW_CYC =
        int'($floor(RAMP_FULL_SLOW_S * CLOCK_HZ / FULL_SCALE));

endpackage : fds_pkg

// ==== hw/fds_ramp_ch.sv ====
// Rate-limited duty follower for one fan drive output
`timescale 1ns/1ps
module fds_ramp_ch #(
    parameter int unsigned SLOT_FAST = fds_pkg::SLOT_FAST_CYC,
    parameter int unsigned SLOT_SLOW = fds_pkg::SLOT_SLOW_CYC
) (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       smooth_on,
    input  wire logic [2:0] rate_code,
    input  wire logic       slow_sel,
    input  wire logic       slow_div4,
    input  wire logic [7:0] target,
    output logic      [7:0] duty
);

    typedef struct packed {
        logic [31:0] cnt;
        logic [7:0]  duty;
    } fds_ramp_t;

    fds_ramp_t   st_r;
    fds_ramp_t   st_nxt;
    logic [31:0] slot_len;
    logic [7:0]  step;
    logic        tick;

    // Slot length from slow-ramp select and the divide-by-four bit
    always_comb
    begin
        slot_len = slow_sel ? SLOT_SLOW : SLOT_FAST;
        if (slow_div4)
            slot_len = {slot_len[29:0], 2'b00};
        step = fds_pkg::RAMP_STEP[rate_code];
        tick = (st_r.cnt >= slot_len - 32'h1);
    end

    // Slot counter and duty stepping
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.cnt = tick ? 32'h0 : st_r.cnt + 32'h1;
        if (!smooth_on)
            st_nxt.duty = target;
        else if (tick)
        begin
            // Clamp so the step never passes the target
            if (target > st_r.duty)
                st_nxt.duty = (target - st_r.duty <= step) ? target : st_r.duty + step;
            else if (target < st_r.duty)
                st_nxt.duty = (st_r.duty - target <= step) ? target : st_r.duty - step;
        end
    end

    // State register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r.cnt  <= 32'h0;
            st_r.duty <= fds_pkg::DUTY_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign duty = st_r.duty;

endmodule : fds_ramp_ch

// ==== hw/fds_sync2.sv ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module fds_sync2 #(
    parameter int W = 3
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fds_sync_t;

    fds_sync_t st_r;
    fds_sync_t st_nxt;

    // First stage feeds only the second stage
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    // State register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign dout = st_r.s2;

endmodule : fds_sync2

// ==== hw/fds_top.sv ====
// Fan drive ramp smoothing: APB registers, floor select, ramps, sense grouping
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module fds_top #(
    parameter int unsigned SLOT_FAST_CYCLES = fds_pkg::SLOT_FAST_CYC,
    parameter int unsigned SLOT_SLOW_CYCLES = fds_pkg::SLOT_SLOW_CYC
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Computed targets per temperature channel: remote one, local, remote two
    input  wire logic [7:0]  target_remote_one,
    input  wire logic [7:0]  target_local,
    input  wire logic [7:0]  target_remote_two,
    // Temperature below start threshold minus hysteresis, per channel
    input  wire logic        below_floor_remote_one,
    input  wire logic        below_floor_local,
    input  wire logic        below_floor_remote_two,
    // Programmed minimum duty per output
    input  wire logic [7:0]  min_duty_one,
    input  wire logic [7:0]  min_duty_two,
    input  wire logic [7:0]  min_duty_three,
    // Speed-sense pins
    input  wire logic        speed_sense_two,
    input  wire logic        speed_sense_three,
    input  wire logic        speed_sense_four,
    // Smoothed duty for each fan drive output
    output logic      [7:0]  fan_drive_one,
    output logic      [7:0]  fan_drive_two,
    output logic      [7:0]  fan_drive_three,
    // Sense inputs measured against fan drive three: {four, three, two}
    output logic      [2:0]  drive_three_sense_mask,
    output logic      [2:0]  drive_three_sense
);

    // Register state
    typedef struct packed {
        logic [7:0]  acou1;
        logic [7:0]  acou2;
        logic [7:0]  cfg6;
        logic        lock;
        logic        auto_mode;
        logic [31:0] rdata;
        logic [2:0]  grp_mask;
        logic [2:0]  grp_sense;
    } fds_regs_t;

    fds_regs_t   st_r;
    fds_regs_t   st_nxt;

    logic [9:0]  idx;
    logic        addr_ok;
    logic        setup_ph;
    logic        wr_fire;
    logic [31:0] rd_mux;
    logic [2:0]  sense_sync;
    logic [2:0]  below_floor;
    logic [2:0]  floor_sel;
    logic [2:0]  smooth_en;
    logic [2:0]  slow_div;
    logic [2:0][2:0] code;
    logic [2:0][7:0] tgt_in;
    logic [2:0][7:0] min_duty;
    logic [2:0][7:0] duty;

    // Word index from the byte address
    always_comb
    begin
        idx      = paddr[11:2];
        setup_ph = psel && !penable;
        wr_fire  = psel && penable && pwrite;
    end

    // Address decode and read data selection
    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0;
        if (paddr[1:0] != 2'b00)
            addr_ok = 1'b0;
        else if (idx == fds_pkg::IDX_ACOU1)
            rd_mux = {24'h0, st_r.acou1};
        else if (idx == fds_pkg::IDX_ACOU2)
            rd_mux = {24'h0, st_r.acou2};
        else if (idx == fds_pkg::IDX_CFG6)
            rd_mux = {24'h0, st_r.cfg6};
        else if (idx == fds_pkg::IDX_CTRL)
            rd_mux = {30'h0, st_r.auto_mode, st_r.lock};
        else if (idx == fds_pkg::IDX_STATUS)
            rd_mux = {8'h0, duty[2], duty[1], duty[0]};
        else
            addr_ok = 1'b0;
    end

    // Zero wait states; unmapped or misaligned access answers with an error
    always_comb
    begin
        pready  = 1'b1;
        pslverr = psel && penable && !addr_ok;
    end

    // Register writes, read capture and sense grouping
    always_comb
    begin
        st_nxt = st_r;
        // Read data captured in the setup phase, held for the access phase
        if (setup_ph && !pwrite)
            st_nxt.rdata = rd_mux;
        if (wr_fire && addr_ok)
        begin
            if (idx == fds_pkg::IDX_ACOU1 && !st_r.lock)
                st_nxt.acou1 = pwdata[7:0];
            else if (idx == fds_pkg::IDX_ACOU2 && !st_r.lock)
                st_nxt.acou2 = pwdata[7:0];
            else if (idx == fds_pkg::IDX_CFG6)
                st_nxt.cfg6 = pwdata[7:0];
            else if (idx == fds_pkg::IDX_CTRL)
            begin
                // Lock stays set until reset
                st_nxt.lock      = st_r.lock | pwdata[fds_pkg::F_LOCK];
                st_nxt.auto_mode = pwdata[fds_pkg::F_AUTO];
            end
        end
        // Which sense inputs follow fan drive three
        if (st_r.acou1[fds_pkg::F_SYNC])
            st_nxt.grp_mask = 3'b111;
        else
            st_nxt.grp_mask = 3'b110;
        st_nxt.grp_sense = sense_sync & st_r.grp_mask;
    end

    // State register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r.acou1     <= fds_pkg::REMOTE_ONE_RAMP_CODE_RST;
            st_r.acou2     <= fds_pkg::REMOTE_ONE_RAMP_CODE_RST;
            st_r.cfg6      <= fds_pkg::CFG6_RST;
            st_r.lock      <= 1'b0;
            st_r.auto_mode <= 1'b0;
            st_r.rdata     <= 32'h0;
            st_r.grp_mask  <= 3'b110;
            st_r.grp_sense <= 3'b000;
        end
        else
            st_r <= st_nxt;
    end

    // Sense pins cross into the clock domain
    fds_sync2 #(
        .W      (3)
    ) u_sense_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .din    ({speed_sense_four, speed_sense_three, speed_sense_two}),
        .dout   (sense_sync)
    );

    // Per-output controls: one from remote one, two from local, three from remote two
    always_comb
    begin
        tgt_in      = {target_remote_two, target_local, target_remote_one};
        min_duty    = {min_duty_three, min_duty_two, min_duty_one};
        below_floor = {below_floor_remote_two, below_floor_local, below_floor_remote_one};
        floor_sel   = st_r.acou1[fds_pkg::F_OUT_ONE_FLOOR_SELECT +: 3];
        code[0]     = st_r.acou1[fds_pkg::F_CODE_LO +: 3];
        code[1]     = st_r.acou2[fds_pkg::F_CODE_LO +: 3];
        code[2]     = st_r.acou2[fds_pkg::F_CODE_HI +: 3];
        smooth_en   = {st_r.acou2[fds_pkg::F_EN_HI],
                       st_r.acou2[fds_pkg::F_EN_LO],
                       st_r.acou1[fds_pkg::F_EN_LO]};
        slow_div    = st_r.cfg6[2:0];
    end

    // One ramp per output
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_out
            // Local per output so each target has exactly one driving process
            logic [7:0] tgt_eff;

            // Target after floor and minimum handling in automatic mode
            always_comb
            begin
                if (!st_r.auto_mode)
                    tgt_eff = tgt_in[g];
                else if (below_floor[g])
                    tgt_eff = floor_sel[g] ? min_duty[g] : 8'h00;
                else if (tgt_in[g] < min_duty[g])
                    tgt_eff = min_duty[g];
                else
                    tgt_eff = tgt_in[g];
            end

            fds_ramp_ch #(
                .SLOT_FAST (SLOT_FAST_CYCLES),
                .SLOT_SLOW (SLOT_SLOW_CYCLES)
            ) u_ramp (
                .clock     (clock),
                .arst_n    (arst_n),
                .smooth_on (smooth_en[g] && st_r.auto_mode),
                .rate_code (code[g]),
                .slow_sel  (st_r.cfg6[fds_pkg::F_SLOW_SEL]),
                .slow_div4 (slow_div[g]),
                .target    (tgt_eff),
                .duty      (duty[g])
            );
        end
    endgenerate

    // Outputs
    assign prdata                 = st_r.rdata;
    assign fan_drive_one          = duty[0];
    assign fan_drive_two          = duty[1];
    assign fan_drive_three        = duty[2];
    assign drive_three_sense_mask = st_r.grp_mask;
    assign drive_three_sense      = st_r.grp_sense;

endmodule : fds_top

// ==== verif/fan_drive_ramp_smoothing_tb.sv ====
// Self-checking testbench for the fan drive ramp smoothing block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module fan_drive_ramp_smoothing_tb;
    logic        clock = 1'b0, arst_n = 1'b0, spin = 1'b1, e;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [7:0]  target_remote_one = 8'h00, target_local = 8'h00, target_remote_two = 8'h00;
    logic [7:0]  min_duty_one = 8'h20, min_duty_two = 8'h30, min_duty_three = 8'h40;
    logic        below_floor_remote_one = 1'b0, below_floor_local = 1'b0, below_floor_remote_two = 1'b0;
    logic        speed_sense_two, speed_sense_three, speed_sense_four;
    logic [7:0]  fan_drive_one, fan_drive_two, fan_drive_three;
    logic [2:0]  drive_three_sense_mask, drive_three_sense;
    int          bad_count = 0, checks = 0;

    fds_top #(.SLOT_FAST_CYCLES(10), .SLOT_SLOW_CYCLES(14)) dut_u (
        .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .target_remote_one(target_remote_one), .target_local(target_local), .target_remote_two(target_remote_two),
        .below_floor_remote_one(below_floor_remote_one), .below_floor_local(below_floor_local),
        .below_floor_remote_two(below_floor_remote_two), .min_duty_one(min_duty_one), .min_duty_two(min_duty_two),
        .min_duty_three(min_duty_three), .speed_sense_two(speed_sense_two), .speed_sense_three(speed_sense_three),
        .speed_sense_four(speed_sense_four), .fan_drive_one(fan_drive_one), .fan_drive_two(fan_drive_two),
        .fan_drive_three(fan_drive_three), .drive_three_sense_mask(drive_three_sense_mask),
        .drive_three_sense(drive_three_sense));
    fds_fan_model fan_u (.clock(clock), .spin(spin), .tach_two(speed_sense_two), .tach_three(speed_sense_three),
                         .tach_four(speed_sense_four));

    // Clock and watchdog
    initial
    begin
        forever #2 clock = ~clock;
    end
    initial
    begin
        #40000; // About fourteen times the expected run length
        bad_count++;
        give_verdict();
    end

    task automatic give_verdict();
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Ends at the first edge that sees pready high
        do
            @(posedge clock);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h000000, d});
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] x);
        apb(a, 1'b0, 32'h0);
        `CHK(nm, {24'h000000, x}, q)
    endtask : rd_chk

    // Two consecutive ramp steps: size of each, slot length between them
    task automatic step_chk(input logic [7:0] dl, input int gap);
        logic [7:0] p;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            p = fan_drive_one;
            n = 0;
            while (fan_drive_one === p && n < 300)
            begin
                @(negedge clock);
                n++;
            end
            `CHK("ramp_step", dl, fan_drive_one - p)
            if (k == 1)
                `CHK("ramp_gap", gap, n)
        end
    endtask : step_chk

    // Settle drive one at its floor, then ramp it up with smoothing on
    task automatic ramp(input logic [7:0] cfg, input int c, input int gap);
        wr(12'h188, 8'h00);
        wr(12'h040, cfg);
        @(posedge clock);
        target_remote_one <= 8'h00;
        idle(3);
        wr(12'h188, 8'h08 | 8'(c));
        @(posedge clock);
        target_remote_one <= 8'hFF;
        step_chk(fds_pkg::RAMP_STEP[c], gap);
    endtask : ramp

    // Test sequence
    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk("ramp_remote_one", 12'h188, 8'h00);
        rd_chk("ramp_local", 12'h18C, 8'h00);
        apb(12'h004, 1'b0, 32'h0);
        `CHK("unmapped_err", 1'h1, e)
        `CHK("sense_mask", 3'h6, drive_three_sense_mask)
        wr(12'h188, 8'h10);
        @(posedge clock);
        spin <= 1'b0;
        idle(8);
        `CHK("sense_grouped", 3'h7, drive_three_sense)
        @(posedge clock);
        spin <= 1'b1;
        below_floor_remote_one <= 1'b1;
        below_floor_local <= 1'b1;
        below_floor_remote_two <= 1'b1;
        target_remote_one <= 8'h50;
        target_local <= 8'h50;
        target_remote_two <= 8'h50;
        wr(12'h1C0, 8'h02);
        wr(12'h188, 8'h00);
        idle(4);
        `CHK("floor_off_one", 8'h00, fan_drive_one)
        `CHK("floor_off_two", 8'h00, fan_drive_two)
        `CHK("floor_off_three", 8'h00, fan_drive_three)
        wr(12'h188, 8'hE0);
        idle(4);
        `CHK("floor_min_one", 8'h20, fan_drive_one)
        `CHK("floor_min_two", 8'h30, fan_drive_two)
        `CHK("floor_min_three", 8'h40, fan_drive_three)
        @(posedge clock);
        below_floor_remote_one <= 1'b0;
        below_floor_local <= 1'b0;
        target_remote_one <= 8'h10;
        target_local <= 8'h90;
        idle(4);
        `CHK("clamp_min", 8'h20, fan_drive_one)
        `CHK("above_min", 8'h90, fan_drive_two)
        @(posedge clock);
        target_remote_one <= 8'hC0;
        idle(3);
        `CHK("jump", 8'hC0, fan_drive_one)
        ramp(8'h80, 0, 14);
        ramp(8'h01, 0, 40);
        ramp(8'h81, 7, 56);
        for (int c = 0; c < 8; c++)
            ramp(8'h00, c, 10);
        idle(80);
        `CHK("top_no_overshoot", 8'hFF, fan_drive_one)
        @(posedge clock);
        target_remote_one <= 8'h00;
        step_chk(8'hD0, 10);
        idle(80);
        `CHK("floor_no_overshoot", 8'h20, fan_drive_one)
        wr(12'h188, 8'h55);
        wr(12'h1C0, 8'h03);
        apb(12'h188, 1'b1, 32'h000000AA);
        `CHK("locked_err", 1'h0, e)
        rd_chk("locked_remote_one", 12'h188, 8'h55);
        wr(12'h18C, 8'h66);
        rd_chk("locked_local", 12'h18C, 8'h00);
        give_verdict();
    end
endmodule : fan_drive_ramp_smoothing_tb

// ==== verif/fds_checker.sv ====
// Port-level assertions for the fan drive ramp smoothing block
`timescale 1ns/1ps
module fds_checker #(
    parameter int unsigned SLOT_FAST_CYCLES = 10,
    parameter int unsigned SLOT_SLOW_CYCLES = 14
) (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        speed_sense_three,
    input wire logic        speed_sense_four,
    input wire logic [7:0]  fan_drive_one,
    input wire logic [2:0]  drive_three_sense_mask,
    input wire logic [2:0]  drive_three_sense
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Bus answers and locked writes
    lock_quiet_a: assert property (psel && penable && pwrite && paddr[11:3] == 9'h031
        && paddr[1:0] == 2'b00 |-> pready && !pslverr)
        else $error("acoustics write answered with an error");
    pready_high_a: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("access phase not answered");
    // Speed-sense grouping onto drive three
    mask_fixed_a: assert property (drive_three_sense_mask[2:1] == 2'h3)
        else $error("sense three or four left drive three");
    sense_two_a: assert property (!drive_three_sense_mask[0] && $past(!drive_three_sense_mask[0])
        |-> !drive_three_sense[0])
        else $error("sense two seen while ungrouped");
    sense_three_a: assert property (speed_sense_three [*6] |-> drive_three_sense[1])
        else $error("sense three level lost");
    sense_four_a: assert property ((!speed_sense_four) [*6] |-> !drive_three_sense[2])
        else $error("sense four level stuck high");
    // State right after reset
    reset_zero_a: assert property ($rose(arst_n) |-> fan_drive_one == 8'h00)
        else $error("drive one not off after reset");
    mask_reset_a: assert property ($rose(arst_n) |-> drive_three_sense_mask == 3'h6)
        else $error("grouping not off after reset");

    // Main scenarios reached
    cover property (psel && penable && pwrite && paddr == 12'h188);
    cover property ($changed(fan_drive_one));
    cover property (drive_three_sense_mask[0] && drive_three_sense[0]);
endmodule : fds_checker

bind fds_top fds_checker #(.SLOT_FAST_CYCLES(SLOT_FAST_CYCLES), .SLOT_SLOW_CYCLES(SLOT_SLOW_CYCLES)) chk_u (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .speed_sense_three(speed_sense_three), .speed_sense_four(speed_sense_four),
    .fan_drive_one(fan_drive_one), .drive_three_sense_mask(drive_three_sense_mask),
    .drive_three_sense(drive_three_sense));

// ==== verif/fds_fan_model.sv ====
// Fan model: tach pulse trains on the three speed-sense pins
`timescale 1ns/1ps
module fds_fan_model (
    input  wire logic clock,
    input  wire logic spin,
    output logic      tach_two = 1'b1,
    output logic      tach_three = 1'b1,
    output logic      tach_four = 1'b1
);
    logic [7:0] cnt_r = 8'h00;

    // Each fan turns at its own rate; a stopped fan drives its pin high
    always @(posedge clock)
    begin
        cnt_r <= cnt_r + 8'h01;
        tach_two <= spin ? cnt_r[3] : 1'b1;
        tach_three <= spin ? cnt_r[4] : 1'b1;
        tach_four <= spin ? cnt_r[5] : 1'b1;
    end
endmodule : fds_fan_model
